//--- common/ckgcfg_pkg.sv
package ckgcfg_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_INDEX   = 8'h01;
  localparam logic [7:0] ADDR_ASSOC   = 8'h02;
  localparam logic [7:0] ADDR_SUSP    = 8'h03;
  localparam logic [7:0] ADDR_PLLSD   = 8'h04;
  localparam logic [7:0] ADDR_REFSEL  = 8'h05;
  localparam logic [7:0] ADDR_RSVD6   = 8'h06;
  localparam logic [7:0] ADDR_XTAL    = 8'h07;
  localparam logic [7:0] ADDR_RSVD8   = 8'h08;
  localparam logic [7:0] ADDR_RSVD9   = 8'h09;
  localparam logic [7:0] ADDR_LOOP4   = 8'h0A;
  localparam logic [7:0] ADDR_LOOP5   = 8'h0B;
  localparam logic [7:0] ADDR_LOOP0   = 8'h0C;
  localparam logic [7:0] ADDR_LOOP1   = 8'h0D;
  localparam logic [7:0] ADDR_LOOP2   = 8'h0E;
  localparam logic [7:0] ADDR_LOOP3   = 8'h0F;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_INDEX    = 8'h00;
  localparam logic [7:0] RST_ASSOC    = 8'h02;
  localparam logic [7:0] RST_SUSP     = 8'h02;
  localparam logic [7:0] RST_PLLSD    = 8'h0F;
  localparam logic [7:0] RST_REFSEL   = 8'h04;
  localparam logic [7:0] RST_XTAL     = 8'h00;
  localparam logic [7:0] RST_LOOP     = 8'h10;

  // ==========================================================================
  // Writable bit masks; all other bits are reserved and read as zero.
  localparam logic [7:0] MASK_MODE    = 8'h01;
  localparam logic [7:0] MASK_INDEX   = 8'h07;
  localparam logic [7:0] MASK_ASSOC   = 8'hFF;
  localparam logic [7:0] MASK_SUSP    = 8'h7F;
  localparam logic [7:0] MASK_PLLSD   = 8'h8F;
  localparam logic [7:0] MASK_REFSEL  = 8'h04;
  localparam logic [7:0] MASK_XTAL    = 8'h1F;
  localparam logic [7:0] MASK_LOOP    = 8'hFF;

  // ==========================================================================
  // Field positions.
  localparam int MODE_BIT    = 0;
  localparam int SHUT_BIT    = 7;
  localparam int REF_BIT     = 2;
  localparam int CAP_BIT     = 7;
  localparam int PUMP_LSB    = 4;
  localparam int PUMP_W      = 3;
  localparam int RES_W       = 4;
  localparam int NUM_OUT     = 7;
  localparam int NUM_PLL     = 4;
  localparam int NUM_CFG     = 6;
  localparam int IDX_W       = 3;
  localparam int XTAL_W      = 5;

  // ==========================================================================
  // Loop filter configuration order in the byte map: 4, 5, 0, 1, 2, 3.
  function automatic logic [IDX_W-1:0] loop_slot(input logic [IDX_W-1:0] cfg);
    return (cfg >= IDX_W'(4)) ? IDX_W'(cfg - IDX_W'(4)) : IDX_W'(cfg + IDX_W'(2));
  endfunction : loop_slot

endpackage : ckgcfg_pkg

//--- hdl/ckgcfg_out_ctrl.sv
`timescale 1ns/100ps
module ckgcfg_out_ctrl #(
  parameter int NUM_OUT = 7
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire logic [NUM_OUT-1:0] i_assoc,
  input  wire logic [NUM_OUT-1:0] i_suspend_n,
  input  wire logic               i_pin_active,
  output logic      [NUM_OUT-1:0] o_enable
);

  initial
  begin
    if (NUM_OUT < 1) $error("NUM_OUT must be positive.");
  end

  // ==========================================================================
  // Per output enable from override and pin association.
  typedef struct packed {
    logic [NUM_OUT-1:0] en;
  } ckgcfg_oc_t;

  ckgcfg_oc_t st_q;
  ckgcfg_oc_t st_d;

  always_comb
  begin
    st_d.en = ~(i_assoc & {NUM_OUT{i_pin_active}});  // see (R2) see (R3)
    st_d.en = st_d.en & i_suspend_n;                 // see (R5)
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_enable = st_q.en;

endmodule : ckgcfg_out_ctrl

//--- hdl/ckgcfg_regs.sv
`timescale 1ns/100ps
// Overview of operation
// (R1) Bit 0 of byte 0x00 picks hardware pin selection (0) or the software index field (1).
// (R2) An output whose association bit is 1 is suspended while the shutdown/enable pin is active; the code does so only when bit 7 of byte 0x04 is 1.
// (R3) An output whose association bit is 0 stays enabled whatever the pin does.
// (R4) A pin-suspended output takes the disable style chosen by its own disable-mode bits.
// (R5) An output whose active-low suspend bit is 0 is suspended, overriding the association.
// (R6) A PLL whose active-low suspend bit is 0 is suspended, and all four run after reset.
// (R7) Bit 7 of byte 0x04 chooses full shutdown or output-enable behaviour for the pin.
// (R8) The reference comes from the crystal when the select bit is 0 and the clock pin when 1.
// (R9) The crystal load capacitance follows the five-bit code in byte 0x07.
// (R10) Six loop filter sets live in bytes 0x0A to 0x0F and the active one is used.
// (R11) The host writes zeros to reserved bits and ignores their read value.
module ckgcfg_regs #(
  parameter int NUM_OUT = ckgcfg_pkg::NUM_OUT
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_wr_en,
  input  wire logic               i_rd_en,
  input  wire logic [7:0]         i_addr,
  input  wire logic [7:0]         i_wr_data,
  input  wire logic [2:0]         i_sel_pins,
  input  wire logic               i_shutdown_enable_pin,
  input  wire logic [NUM_OUT-1:0] i_output_disable_style,
  output logic      [7:0]         o_rd_data,
  output logic                    o_rd_valid,
  output logic      [NUM_OUT-1:0] o_output_enable,
  output logic      [NUM_OUT-1:0] o_output_disable_style,
  output logic      [3:0]         o_pll_run,
  output logic                    o_device_shutdown,
  output logic                    o_reference_source_bit,
  output logic      [4:0]         o_crystal_cap_code,
  output logic      [2:0]         o_active_config,
  output logic                    o_loop_cap_select,
  output logic      [2:0]         o_charge_pump_current,
  output logic      [3:0]         o_loop_resistor_code
);

  initial
  begin
    if (NUM_OUT != ckgcfg_pkg::NUM_OUT)
      $error("NUM_OUT must match the register map.");
    if (ckgcfg_pkg::NUM_CFG > 8)
      $error("Loop filter sets must fit the three-bit index.");
    if (ckgcfg_pkg::NUM_PLL != 4)
      $error("The PLL run field is four bits wide.");
  end

  // ==========================================================================
  // State.
  typedef struct packed {
    // Stored register bytes.
    logic [7:0]                       mode;
    logic [7:0]                       index;
    logic [7:0]                       assoc;
    logic [7:0]                       susp;
    logic [7:0]                       pllsd;
    logic [7:0]                       refsel;
    logic [7:0]                       xtal;
    logic [ckgcfg_pkg::NUM_CFG-1:0][7:0] loop;
    // Registered answers and derived state.
    logic [7:0]                       rd_data;
    logic                             rd_valid;
    logic [2:0]                       active;
    logic [7:0]                       loop_act;
    logic [NUM_OUT-1:0]               style;
    logic                             shut;
  } ckgcfg_st_t;

  ckgcfg_st_t st_q;
  ckgcfg_st_t st_d;
  logic       pin_active;
  logic [2:0] cfg_pick;

  // ==========================================================================
  // Position of a loop filter byte inside the stored array.
  function automatic logic [2:0] loop_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - ckgcfg_pkg::ADDR_LOOP4;
    return d[2:0];
  endfunction : loop_index

  // ==========================================================================
  // Byte readback with reserved bits forced to zero.
  function automatic logic [7:0] read_byte(input ckgcfg_st_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ckgcfg_pkg::ADDR_MODE:   r = s.mode;
      ckgcfg_pkg::ADDR_INDEX:  r = s.index;
      ckgcfg_pkg::ADDR_ASSOC:  r = s.assoc;
      ckgcfg_pkg::ADDR_SUSP:   r = s.susp;
      ckgcfg_pkg::ADDR_PLLSD:  r = s.pllsd;
      ckgcfg_pkg::ADDR_REFSEL: r = s.refsel;
      ckgcfg_pkg::ADDR_XTAL:   r = s.xtal;
      ckgcfg_pkg::ADDR_LOOP4,
      ckgcfg_pkg::ADDR_LOOP5,
      ckgcfg_pkg::ADDR_LOOP0,
      ckgcfg_pkg::ADDR_LOOP1,
      ckgcfg_pkg::ADDR_LOOP2,
      ckgcfg_pkg::ADDR_LOOP3:  r = s.loop[loop_index(a)];  // see (R10)
      // Unmapped and reserved bytes read zero.
      default:                 r = 8'h00;
    endcase
    return r;
  endfunction : read_byte

  // ==========================================================================
  // Pin role and active configuration.
  // The pin is active high in both of its roles.
  assign pin_active = i_shutdown_enable_pin;

  // Active configuration from pins or software index.
  assign cfg_pick = st_q.mode[ckgcfg_pkg::MODE_BIT] ? st_q.index[2:0] : i_sel_pins;  // see (R1)

  // ==========================================================================
  // Next state.
  always_comb
  begin
    st_d          = st_q;
    // Reads capture the addressed byte, which then holds until the next read.
    st_d.rd_valid = i_rd_en;
    if (i_rd_en)
    begin
      st_d.rd_data = read_byte(st_q, i_addr);
    end
    // Writes keep only the defined bits of each byte.
    if (i_wr_en)
    begin
      unique case (i_addr)
        ckgcfg_pkg::ADDR_MODE:   st_d.mode   = i_wr_data & ckgcfg_pkg::MASK_MODE;
        ckgcfg_pkg::ADDR_INDEX:  st_d.index  = i_wr_data & ckgcfg_pkg::MASK_INDEX;
        ckgcfg_pkg::ADDR_ASSOC:  st_d.assoc  = i_wr_data & ckgcfg_pkg::MASK_ASSOC;
        ckgcfg_pkg::ADDR_SUSP:   st_d.susp   = i_wr_data & ckgcfg_pkg::MASK_SUSP;
        ckgcfg_pkg::ADDR_PLLSD:  st_d.pllsd  = i_wr_data & ckgcfg_pkg::MASK_PLLSD;
        ckgcfg_pkg::ADDR_REFSEL: st_d.refsel = i_wr_data & ckgcfg_pkg::MASK_REFSEL;
        ckgcfg_pkg::ADDR_XTAL:   st_d.xtal   = i_wr_data & ckgcfg_pkg::MASK_XTAL;
        ckgcfg_pkg::ADDR_LOOP4,
        ckgcfg_pkg::ADDR_LOOP5,
        ckgcfg_pkg::ADDR_LOOP0,
        ckgcfg_pkg::ADDR_LOOP1,
        ckgcfg_pkg::ADDR_LOOP2,
        ckgcfg_pkg::ADDR_LOOP3:
          st_d.loop[loop_index(i_addr)] = i_wr_data;  // see (R10)
        default: ;
      endcase
    end
    // Active configuration and its loop filter set.
    st_d.active = cfg_pick;
    if (cfg_pick < 3'(ckgcfg_pkg::NUM_CFG))
    begin
      st_d.loop_act = st_q.loop[ckgcfg_pkg::loop_slot(cfg_pick)];  // see (R10)
    end
    else
    begin
      st_d.loop_act = ckgcfg_pkg::RST_LOOP;
    end
    // Pin driven state.
    st_d.style = i_output_disable_style;  // see (R4)
    st_d.shut  = pin_active & ~st_q.pllsd[ckgcfg_pkg::SHUT_BIT];  // see (R7)
  end

  // ==========================================================================
  // State register with synchronous reset.
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      st_q          <= '0;
      st_q.mode     <= ckgcfg_pkg::RST_MODE;
      st_q.index    <= ckgcfg_pkg::RST_INDEX;
      st_q.assoc    <= ckgcfg_pkg::RST_ASSOC;
      st_q.susp     <= ckgcfg_pkg::RST_SUSP;
      st_q.pllsd    <= ckgcfg_pkg::RST_PLLSD;  // see (R6)
      st_q.refsel   <= ckgcfg_pkg::RST_REFSEL;
      st_q.xtal     <= ckgcfg_pkg::RST_XTAL;
      st_q.loop     <= {ckgcfg_pkg::NUM_CFG{ckgcfg_pkg::RST_LOOP}};
      st_q.loop_act <= ckgcfg_pkg::RST_LOOP;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Output enables, only gated by the pin in output-enable style.
  // The sub-block registers again, so enables trail a write by two cycles.
  ckgcfg_out_ctrl #(
    .NUM_OUT (NUM_OUT)
  ) u_out_ctrl (
    .i_core_clk   (i_core_clk),
    .i_sys_rst    (i_sys_rst),
    .i_assoc      (st_q.assoc[NUM_OUT-1:0]),
    .i_suspend_n  (st_q.susp[NUM_OUT-1:0]),
    .i_pin_active (pin_active & st_q.pllsd[ckgcfg_pkg::SHUT_BIT]),  // see (R2) see (R7)
    .o_enable     (o_output_enable)
  );

  // ==========================================================================
  // Register driven outputs.
  // Read answer.
  assign o_rd_data              = st_q.rd_data;
  assign o_rd_valid             = st_q.rd_valid;

  // Output style, PLL run and shutdown.
  assign o_output_disable_style = st_q.style;
  assign o_pll_run              = st_q.pllsd[ckgcfg_pkg::NUM_PLL-1:0];  // see (R6)
  assign o_device_shutdown      = st_q.shut;

  // Reference and crystal.
  assign o_reference_source_bit = st_q.refsel[ckgcfg_pkg::REF_BIT];  // see (R8)
  assign o_crystal_cap_code     = st_q.xtal[ckgcfg_pkg::XTAL_W-1:0];  // see (R9)

  // Active configuration and its loop filter fields.
  assign o_active_config        = st_q.active;
  assign o_loop_cap_select      = st_q.loop_act[ckgcfg_pkg::CAP_BIT];
  assign o_charge_pump_current  = st_q.loop_act[ckgcfg_pkg::PUMP_LSB +: ckgcfg_pkg::PUMP_W];
  assign o_loop_resistor_code   = st_q.loop_act[ckgcfg_pkg::RES_W-1:0];

endmodule : ckgcfg_regs

//--- tb/ckgcfg_regs_asserts.sv
`timescale 1ns/100ps
module ckgcfg_regs_asserts #(
  parameter int NUM_OUT = 7
) (
  input wire logic               i_core_clk,
  input wire logic               i_sys_rst,
  input wire logic               i_wr_en,
  input wire logic               i_rd_en,
  input wire logic [7:0]         i_addr,
  input wire logic [7:0]         i_wr_data,
  input wire logic [2:0]         i_sel_pins,
  input wire logic [NUM_OUT-1:0] i_output_disable_style,
  input wire logic [7:0]         o_rd_data,
  input wire logic               o_rd_valid,
  input wire logic [NUM_OUT-1:0] o_output_enable,
  input wire logic [NUM_OUT-1:0] o_output_disable_style,
  input wire logic [3:0]         o_pll_run,
  input wire logic               o_reference_source_bit,
  input wire logic [4:0]         o_crystal_cap_code,
  input wire logic [2:0]         o_active_config
);
  // ====================================
  // Checks on the register port.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_pll_write: assert property ((i_wr_en && i_addr == ckgcfg_pkg::ADDR_PLLSD)
    |=> o_pll_run == $past(i_wr_data[3:0])) else $error("pll run not updated");
  a_pll_read: assert property ((i_rd_en && i_addr == ckgcfg_pkg::ADDR_PLLSD)
    |=> o_rd_valid && o_rd_data[3:0] == $past(o_pll_run)) else $error("pll read wrong");
  a_ref_write: assert property ((i_wr_en && i_addr == ckgcfg_pkg::ADDR_REFSEL)
    |=> o_reference_source_bit == $past(i_wr_data[2])) else $error("ref bit wrong");
  a_ref_read: assert property ((i_rd_en && i_addr == ckgcfg_pkg::ADDR_REFSEL)
    |=> o_rd_data == {5'h00, $past(o_reference_source_bit), 2'h0}) else $error("ref read");
  a_xtal_write: assert property ((i_wr_en && i_addr == ckgcfg_pkg::ADDR_XTAL)
    |=> o_crystal_cap_code == $past(i_wr_data[4:0])) else $error("cap code wrong");
  a_rsvd_zero: assert property ((i_rd_en && (i_addr == 8'h06 || i_addr > 8'h0F))
    |=> o_rd_data == 8'h00) else $error("reserved read not zero");
  a_mode_hw: assert property ((i_wr_en && i_addr == 8'h00 && !i_wr_data[0])
    ##1 (!i_wr_en && $stable(i_sel_pins)) [*2] |-> o_active_config == i_sel_pins)
    else $error("pins not selected");
  a_susp_all: assert property ((i_wr_en && i_addr == 8'h03 && i_wr_data[6:0] == 7'h00)
    ##1 !i_wr_en |=> o_output_enable == '0) else $error("override ignored");
  a_style_copy: assert property (!$past(i_sys_rst)
    |-> o_output_disable_style == $past(i_output_disable_style)) else $error("style lost");
endmodule : ckgcfg_regs_asserts
bind ckgcfg_regs ckgcfg_regs_asserts #(.NUM_OUT(NUM_OUT)) u_chk (.i_core_clk, .i_sys_rst,
  .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .i_sel_pins, .i_output_disable_style, .o_rd_data,
  .o_rd_valid, .o_output_enable, .o_output_disable_style, .o_pll_run, .o_reference_source_bit,
  .o_crystal_cap_code, .o_active_config);

//--- tb/ckgcfg_host.sv
`timescale 1ns/100ps
module ckgcfg_host (
  input  wire logic       i_core_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wr_data
);
  // ====================================
  // Byte transfers; callers pass zeros in reserved bits.
  initial {o_wr_en, o_rd_en, o_addr, o_wr_data} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1 {o_wr_en, o_addr, o_wr_data} = {1'b1, a, d};
    @(posedge i_core_clk);
    #1 {o_wr_en, o_addr, o_wr_data} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_core_clk);
    #1 {o_rd_en, o_addr} = {1'b1, a};
    @(posedge i_core_clk);
    #1 {o_rd_en, o_addr} = {1'b0, ~a};
    d = i_rd_data;
    v = i_rd_valid;
  endtask : rd
endmodule : ckgcfg_host

//--- tb/ckgcfg_regs_tb.sv
`timescale 1ns/100ps
module ckgcfg_regs_tb;
  logic       clk, rst, wr, rd, pin, vld, sd, rsb, lcs;
  logic [7:0] addr, wd, rdat;
  logic [2:0] sel, act, pump;
  logic [6:0] sty, en, sto;
  logic [3:0] pll, res;
  logic [4:0] cap;
  int         errors, total_checks;
  ckgcfg_host u_host (.i_core_clk(clk), .i_rd_valid(vld), .i_rd_data(rdat), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(addr), .o_wr_data(wd));
  ckgcfg_regs DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(addr), .i_wr_data(wd), .i_sel_pins(sel), .i_shutdown_enable_pin(pin),
    .i_output_disable_style(sty), .o_rd_data(rdat), .o_rd_valid(vld), .o_output_enable(en),
    .o_output_disable_style(sto), .o_pll_run(pll), .o_device_shutdown(sd),
    .o_reference_source_bit(rsb), .o_crystal_cap_code(cap), .o_active_config(act),
    .o_loop_cap_select(lcs), .o_charge_pump_current(pump), .o_loop_resistor_code(res));
  // ====================================
  // Shared checking tasks.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk(d, e);
    chk({7'h00, v}, 8'h01);
  endtask : rdchk
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // ====================================
  // Scenarios.
  task automatic t_map();
    logic [7:0] rv [17] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h0F, 8'h04, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h00};
    logic [7:0] mv [17] = '{8'h01, 8'h07, 8'hFF, 8'h7F, 8'h8F, 8'h04, 8'h00, 8'h1F, 8'h00,
      8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    chk({4'h0, pll}, 8'h0F);
    for (int i = 0; i < 17; i++) rdchk(8'(i), rv[i]);
    for (int i = 0; i < 17; i++) u_host.wr(8'(i), mv[i]);
    for (int i = 0; i < 17; i++) rdchk(8'(i), mv[i]);
  endtask : t_map
  task automatic t_config();
    int s;
    for (int i = 0; i < 6; i++) u_host.wr(8'h0A + 8'(i), 8'h11 * 8'(i + 1));
    u_host.wr(8'h00, 8'h01);
    for (int c = 0; c < 8; c++)
    begin
      s = (c >= 4) ? c - 4 : c + 2;
      u_host.wr(8'h01, 8'(c));
      settle();
      chk({5'h00, act}, 8'(c));
      chk({lcs, pump, res}, (c > 5) ? 8'h10 : 8'h11 * 8'(s + 1));
    end
    sel = 3'h3;
    u_host.wr(8'h00, 8'h00);
    settle();
    chk({5'h00, act}, 8'h03);
    chk({lcs, pump, res}, 8'h66);
  endtask : t_config
  task automatic t_outputs();
    u_host.wr(8'h03, 8'h7F);
    u_host.wr(8'h02, 8'h05);
    u_host.wr(8'h04, 8'h8A);
    u_host.wr(8'h05, 8'h00);
    u_host.wr(8'h07, 8'h15);
    pin = 1'b1;
    sty = 7'h55;
    settle();
    chk({1'b0, en}, 8'h7A);
    chk({1'b0, sto}, 8'h55);
    chk({7'h00, sd}, 8'h00);
    chk({pll, 3'h0, rsb}, 8'hA0);
    chk({3'h0, cap}, 8'h15);
    u_host.wr(8'h03, 8'h3F);
    pin = 1'b0;
    settle();
    chk({1'b0, en}, 8'h3F);
    u_host.wr(8'h04, 8'h0F);
    u_host.wr(8'h05, 8'h04);
    pin = 1'b1;
    settle();
    chk({1'b0, en}, 8'h3F);
    chk({6'h00, sd, rsb}, 8'h03);
    u_host.wr(8'h03, 8'h00);
    settle();
    chk({1'b0, en}, 8'h00);
  endtask : t_outputs
  // ====================================
  // Clock, reset, sequence and watchdog.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
  initial
  begin
    {rst, pin, sel, sty, errors, total_checks} = {1'b1, 11'h000, 64'h0};
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_map();
    t_config();
    t_outputs();
    give_verdict();
  end
endmodule : ckgcfg_regs_tb
